// file: design/serial_flash_boot_config_nv.sv
// boot interface configuration register with its live twin, reached over
// the serial flash link by the read-any and write-any register commands
// assumes sck idles between frames, selN high ends a frame, mode 0 timing
`timescale 1ns/100ps
`include "boot_config_map.svh"

// Behaviour
// - boot config reached only via read-any 65h and write-any 71h commands
// - boot bit 7 picks 4-byte addressing from any reset, default 3-byte
// - address length applies only to commands without fixed address width
// - boot bit 6 sets instruction width from any reset, default clear
// - bit 6 set means 4-4-4 protocol; clear means serial opcodes on io0
// - in four-wide mode opcode, address and data move four bits per clock
// - programming boot bit 6 also programs boot wide-data bit to 1
// - clearing live bit 6 via write-any returns to serial instructions
// - boot bit 6 is one-time programmable and never returns to 0
// - boot bit 5 sets io3 alternate reset function from every reset
// - bit 5 set makes io3 an active-low reset while select is high
// - bit 4 is reserved and reads as zero
// - bits 3 to 0 give 0 to 15 dummy clocks before read data
// - latency defaults to 1000; bit 3 may only be programmed to 0 once
// - latency field sets dummy count of variable-latency reads incl read-any
// - dummy clocks sit between last address clock and first data clock
// - boot register loads live twin at reset; live twin runs interface
// - each one-time bit leaves its default only once
// - live wide-data bit cannot be cleared while live bit 6 is set
module serial_flash_boot_config_nv (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       swResetReq,
  input  wire logic       sck,
  input  wire logic       selN,
  input  wire logic [3:0] ioIn,
  output logic      [3:0] ioOut,
  output logic      [3:0] ioOe,
  output logic            addrLenFour,
  output logic            wideInstr,
  output logic            pinResetEn,
  output logic      [3:0] readDummy,
  output logic            wideData,
  output logic            progBusy
);

  function automatic logic isAddr(input logic [31:0] a, input logic [31:0] ref_a);
    isAddr = (a == ref_a);
  endfunction

  // ---------------- system clock domain ----------------
  logic [7:0]  bootCfg;
  logic [7:0]  liveCfg;
  logic [7:0]  bootOne;
  logic [7:0]  liveOne;
  logic [7:0]  pendVal;
  logic [15:0] progCnt;
  boot_config_pkg::prog_target_t pendTarget;
  logic        wrTogS1;
  logic        wrTogS2;
  logic        wrTogS3;
  logic        io3S1;
  logic        io3S2;
  logic        selS1;
  logic        selS2;
  logic        wrEvent;
  logic        hwReset;
  logic        reload;
  logic        progDone;
  logic        progStart;

  // link-side write capture, stable well before its toggle is seen
  logic        wrTog;
  logic [31:0] wrAddr;
  logic [7:0]  wrData;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrTogS1 <= 1'b0;
      wrTogS2 <= 1'b0;
      wrTogS3 <= 1'b0;
      io3S1   <= 1'b1;
      io3S2   <= 1'b1;
      selS1   <= 1'b1;
      selS2   <= 1'b1;
    end else begin
      wrTogS1 <= wrTog;
      wrTogS2 <= wrTogS1;
      wrTogS3 <= wrTogS2;
      io3S1   <= ioIn[3];
      io3S2   <= io3S1;
      selS1   <= selN;
      selS2   <= selS1;
    end
  end

  assign wrEvent   = wrTogS2 ^ wrTogS3;
  assign hwReset   = liveCfg[`BCFG_BIT_PIN_RESET] & selS2 & ~io3S2;
  assign reload    = hwReset | swResetReq;
  assign progDone  = progBusy && (progCnt == 16'h0001);
  assign progStart = wrEvent && !progBusy &&
                     (isAddr(wrAddr, `BCFG_ADDR_BOOT_IFC) ||
                      isAddr(wrAddr, `BCFG_ADDR_BOOT_ONE));

  // programming timer and the value it will commit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      progBusy   <= 1'b0;
      progCnt    <= 16'h0000;
      pendVal    <= 8'h00;
      pendTarget <= boot_config_pkg::PROG_BOOT_IFC;
    end else if (progStart) begin
      progBusy <= 1'b1;
      progCnt  <= 16'(`BCFG_PROG_CYCLES);
      if (isAddr(wrAddr, `BCFG_ADDR_BOOT_IFC)) begin
        pendTarget <= boot_config_pkg::PROG_BOOT_IFC;
        // one-time bits: 7,6,5,2:0 may only set, bit 3 may only clear
        pendVal <= {bootCfg[7:5] | wrData[7:5], 1'b0,
                    bootCfg[3] & wrData[3], bootCfg[2:0] | wrData[2:0]};
      end else begin
        pendTarget <= boot_config_pkg::PROG_BOOT_ONE;
        pendVal    <= {6'h00, wrData[1] | bootCfg[`BCFG_BIT_WIDE_INSTR], 1'b0};
      end
    end else if (progBusy) begin
      progCnt <= progCnt - 16'h0001;
      if (progDone) begin
        progBusy <= 1'b0;
      end
    end
  end

  // nonvolatile registers, only power-on clears them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bootCfg <= `BCFG_RST_BOOT_IFC;
    end else if (progDone && pendTarget == boot_config_pkg::PROG_BOOT_IFC) begin
      bootCfg <= pendVal;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bootOne <= `BCFG_RST_BOOT_ONE;
    end else if (progDone && pendTarget == boot_config_pkg::PROG_BOOT_ONE) begin
      bootOne <= pendVal;
    end else if (progDone && pendVal[`BCFG_BIT_WIDE_INSTR]) begin
      bootOne[`BCFG_BIT_WIDE_DATA] <= 1'b1;
    end
  end

  // live twin, reloaded from the boot copy on every reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      liveCfg <= `BCFG_RST_BOOT_IFC;
    end else if (reload) begin
      liveCfg <= bootCfg;
    end else if (wrEvent && isAddr(wrAddr, `BCFG_ADDR_LIVE_IFC)) begin
      liveCfg <= wrData & `BCFG_RESERVED_MASK;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      liveOne <= `BCFG_RST_BOOT_ONE;
    end else if (reload) begin
      liveOne <= {6'h00, bootOne[`BCFG_BIT_WIDE_DATA], 1'b0};
    end else if (wrEvent && isAddr(wrAddr, `BCFG_ADDR_LIVE_ONE)) begin
      liveOne <= {6'h00, wrData[1] | liveCfg[`BCFG_BIT_WIDE_INSTR], 1'b0};
    end
  end

  // live settings shown as outputs straight from their flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addrLenFour <= 1'b0;
      wideInstr   <= 1'b0;
      pinResetEn  <= 1'b0;
      readDummy   <= 4'h8;
      wideData    <= 1'b0;
    end else begin
      addrLenFour <= liveCfg[`BCFG_BIT_ADDR_LEN];
      wideInstr   <= liveCfg[`BCFG_BIT_WIDE_INSTR];
      pinResetEn  <= liveCfg[`BCFG_BIT_PIN_RESET];
      readDummy   <= liveCfg[`BCFG_BIT_LAT_MSB:0];
      wideData    <= liveOne[`BCFG_BIT_WIDE_DATA];
    end
  end

  // ---------------- link clock domain ----------------
  logic [39:0] linkView;
  logic [7:0]  sBootCfg;
  logic [7:0]  sLiveCfg;
  logic [7:0]  sBootOne;
  logic [7:0]  sLiveOne;
  logic [7:0]  sStatus;
  logic        wideMode;
  logic [5:0]  clksByte;
  logic [5:0]  addrClks;
  boot_config_pkg::link_state_t linkSt;
  logic [5:0]  cnt;
  logic [31:0] shiftIn;
  logic [31:0] next_shift;
  logic [31:0] addrSeen;
  logic [31:0] cmdAddr;
  logic        isWrite;
  logic [7:0]  rdByte;
  logic [2:0]  outIdx;

  // register view for the link, frozen while selected so a frame sees one value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      linkView <= {8'h00, `BCFG_RST_BOOT_ONE, `BCFG_RST_BOOT_ONE, `BCFG_RST_BOOT_IFC,
                   `BCFG_RST_BOOT_IFC};
    end else if (selS2) begin
      linkView <= {7'h00, progBusy, liveOne, bootOne, liveCfg, bootCfg};
    end
  end

  assign sBootCfg = linkView[7:0];
  assign sLiveCfg = linkView[15:8];
  assign sBootOne = linkView[23:16];
  assign sLiveOne = linkView[31:24];
  assign sStatus  = linkView[39:32];
  assign wideMode = sLiveCfg[`BCFG_BIT_WIDE_INSTR];
  assign clksByte = wideMode ? `BCFG_CLKS_BYTE_WIDE : `BCFG_CLKS_BYTE_SERIAL;
  // both commands here follow the selected length; none is fixed-width
  assign addrClks = sLiveCfg[`BCFG_BIT_ADDR_LEN] ? 6'(clksByte * 6'd4)
                                                  : 6'(clksByte * 6'd3);
  assign next_shift = wideMode ? {shiftIn[27:0], ioIn} : {shiftIn[30:0], ioIn[0]};
  assign addrSeen = sLiveCfg[`BCFG_BIT_ADDR_LEN] ? next_shift : {8'h00, next_shift[23:0]};

  always_ff @(posedge sck or posedge selN) begin
    if (selN) begin
      linkSt  <= boot_config_pkg::LINK_OPCODE;
      cnt     <= 6'h00;
      shiftIn <= 32'h0000_0000;
      isWrite <= 1'b0;
      rdByte  <= 8'h00;
      cmdAddr <= 32'h0000_0000;
    end else begin
      shiftIn <= next_shift;
      cnt     <= cnt + 6'h01;
      unique case (linkSt)
        boot_config_pkg::LINK_OPCODE: begin
          if (cnt == clksByte - 6'h01) begin
            cnt <= 6'h00;
            if (next_shift[7:0] == `BCFG_CMD_READ_ANY ||
                next_shift[7:0] == `BCFG_CMD_WRITE_ANY) begin
              linkSt  <= boot_config_pkg::LINK_ADDR;
              isWrite <= (next_shift[7:0] == `BCFG_CMD_WRITE_ANY);
            end else begin
              linkSt <= boot_config_pkg::LINK_IGNORE;
            end
          end
        end
        boot_config_pkg::LINK_ADDR: begin
          if (cnt == addrClks - 6'h01) begin
            cnt <= 6'h00;
            cmdAddr <= addrSeen;
            if (isWrite) begin
              linkSt <= boot_config_pkg::LINK_WDATA;
            end else if (sLiveCfg[3:0] == 4'h0) begin
              linkSt <= boot_config_pkg::LINK_RDATA;
            end else begin
              linkSt <= boot_config_pkg::LINK_DUMMY;
            end
            if (isAddr(addrSeen, `BCFG_ADDR_BOOT_IFC)) begin
              rdByte <= sBootCfg & `BCFG_RESERVED_MASK;
            end else if (isAddr(addrSeen, `BCFG_ADDR_LIVE_IFC)) begin
              rdByte <= sLiveCfg;
            end else if (isAddr(addrSeen, `BCFG_ADDR_BOOT_ONE)) begin
              rdByte <= sBootOne;
            end else if (isAddr(addrSeen, `BCFG_ADDR_LIVE_ONE)) begin
              rdByte <= sLiveOne;
            end else if (isAddr(addrSeen, `BCFG_ADDR_STATUS_ONE)) begin
              rdByte <= sStatus;
            end else begin
              rdByte <= 8'h00;
            end
          end
        end
        boot_config_pkg::LINK_DUMMY: begin
          if (cnt == {2'b00, sLiveCfg[3:0]} - 6'h01) begin
            linkSt <= boot_config_pkg::LINK_RDATA;
          end
        end
        boot_config_pkg::LINK_WDATA: begin
          if (cnt == clksByte - 6'h01) begin
            linkSt <= boot_config_pkg::LINK_IGNORE;
          end
        end
        boot_config_pkg::LINK_RDATA: begin
          cnt <= 6'h00;
        end
        boot_config_pkg::LINK_IGNORE: begin
          cnt <= 6'h00;
        end
        default: begin
          linkSt <= boot_config_pkg::LINK_IGNORE;
        end
      endcase
    end
  end

  // write capture held until the next write, announced by a toggle
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      wrTog  <= 1'b0;
      wrAddr <= 32'h0000_0000;
      wrData <= 8'h00;
    end else if (!selN && linkSt == boot_config_pkg::LINK_WDATA &&
                 cnt == clksByte - 6'h01) begin
      wrTog  <= ~wrTog;
      wrAddr <= cmdAddr;
      wrData <= next_shift[7:0];
    end
  end

  // read data driven on falling edges, byte repeats while selected
  always_ff @(negedge sck or posedge selN) begin
    if (selN) begin
      ioOut  <= 4'h0;
      ioOe   <= 4'h0;
      outIdx <= 3'h7;
    end else if (linkSt == boot_config_pkg::LINK_RDATA) begin
      if (wideMode) begin
        ioOe   <= 4'hF;
        ioOut  <= outIdx[2] ? rdByte[7:4] : rdByte[3:0];
        outIdx <= outIdx[2] ? 3'h3 : 3'h7;
      end else begin
        ioOe   <= 4'h2;
        ioOut  <= {2'b00, rdByte[outIdx], 1'b0};
        outIdx <= outIdx - 3'h1;
      end
    end
  end

endmodule

// file: inc/boot_config_map.svh
// constants for the boot interface configuration block: opcodes, register
// addresses, field positions, reset values and timing counts
// assumes a 100 MHz system clock and an sdr serial link
`ifndef BOOT_CONFIG_MAP_SVH
`define BOOT_CONFIG_MAP_SVH

`define BCFG_CMD_READ_ANY      8'h65
`define BCFG_CMD_WRITE_ANY     8'h71

`define BCFG_ADDR_STATUS_ONE   32'h0080_0000
`define BCFG_ADDR_BOOT_ONE     32'h0000_0002
`define BCFG_ADDR_LIVE_ONE     32'h0080_0002
`define BCFG_ADDR_BOOT_IFC     32'h0000_0003
`define BCFG_ADDR_LIVE_IFC     32'h0080_0003

`define BCFG_BIT_ADDR_LEN      7
`define BCFG_BIT_WIDE_INSTR    6
`define BCFG_BIT_PIN_RESET     5
`define BCFG_BIT_RESERVED      4
`define BCFG_BIT_LAT_MSB       3
`define BCFG_BIT_WIDE_DATA     1
`define BCFG_BIT_BUSY          0

`define BCFG_RST_BOOT_IFC      8'h08
`define BCFG_RST_BOOT_ONE      8'h00
`define BCFG_RESERVED_MASK     8'hEF

`define BCFG_CLKS_BYTE_SERIAL  6'd8
`define BCFG_CLKS_BYTE_WIDE    6'd2

`define BCFG_CLK_PERIOD_NS     10
`define BCFG_PROG_TIME_NS      2000
`define BCFG_PROG_CYCLES       ((`BCFG_PROG_TIME_NS + `BCFG_CLK_PERIOD_NS - 1) / `BCFG_CLK_PERIOD_NS)

`endif

// file: inc/boot_config_pkg.sv
// types for the boot interface configuration block
// constants live in boot_config_map.svh
package boot_config_pkg;

  typedef enum logic [2:0] {
    LINK_OPCODE = 3'b000,
    LINK_ADDR   = 3'b001,
    LINK_DUMMY  = 3'b010,
    LINK_RDATA  = 3'b011,
    LINK_WDATA  = 3'b100,
    LINK_IGNORE = 3'b101
  } link_state_t;

  typedef enum logic [0:0] {
    PROG_BOOT_IFC = 1'b0,
    PROG_BOOT_ONE = 1'b1
  } prog_target_t;

endpackage

// file: testbench/boot_config_nv_asserts.sv
// assertions on the ports of the boot interface configuration block
// assumes it is bound into serial_flash_boot_config_nv; sck idles outside frames
`timescale 1ns/100ps
`include "boot_config_map.svh"
module boot_config_nv_checker (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       swResetReq,
  input wire logic       sck,
  input wire logic       selN,
  input wire logic [3:0] ioIn,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe,
  input wire logic       addrLenFour,
  input wire logic       wideInstr,
  input wire logic       pinResetEn,
  input wire logic [3:0] readDummy,
  input wire logic       wideData,
  input wire logic       progBusy
);
  logic [8:0] busyCnt;
  logic [6:0] riseCnt;
  logic [5:0] minClk;
  logic [7:0] live;

  assign live = {addrLenFour, wideInstr, pinResetEn, readDummy, wideData};

  // cycles spent busy so far
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      busyCnt <= '0;
    else
      busyCnt <= progBusy ? busyCnt + 9'd1 : 9'd0;

  // sck rises seen in the current frame
  always_ff @(posedge sck or posedge selN)
    if (selN)
      riseCnt <= '0;
    else
      riseCnt <= riseCnt + 7'd1;

  // opcode, address and dummy clocks before read data
  always_comb
    minClk = (wideInstr ? 6'd2 : 6'd8) + {2'b00, readDummy}
           + (wideInstr ? (addrLenFour ? 6'd8 : 6'd6) : (addrLenFour ? 6'd32 : 6'd24));

  sequence swHeld;
    swResetReq [*3];
  endsequence

  sequence liveSettled;
    ##1 $stable(live);
  endsequence

  reset_defaults_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> live == 8'h10) else $error("live values wrong after reset");
  busy_span_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(progBusy) |-> busyCnt == `BCFG_PROG_CYCLES) else $error("busy span wrong");
  commit_live_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(progBusy) |-> $stable(live)) else $error("commit changed live values");
  wide_data_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    wideInstr |-> !$fell(wideData)) else $error("wide data cleared in wide mode");
  sw_reload_a: assert property (@(posedge clk) disable iff (!rstn)
    swHeld |-> liveSettled) else $error("reload not steady");
  oe_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    selN |-> ioOe == 4'h0) else $error("pins driven while deselected");
  oe_width_a: assert property (@(posedge clk) disable iff (!rstn)
    ioOe != 4'h0 |-> ioOe == (wideInstr ? 4'hF : 4'h2)) else $error("wrong drive width");
  data_start_a: assert property (@(posedge sck) disable iff (!rstn || selN)
    $rose(ioOe != 4'h0) |-> {1'b0, minClk} == riseCnt) else $error("data starts off time");
endmodule

bind serial_flash_boot_config_nv boot_config_nv_checker boot_config_nv_checker_inst (
  .clk(clk), .rstn(rstn), .swResetReq(swResetReq), .sck(sck), .selN(selN), .ioIn(ioIn),
  .ioOut(ioOut), .ioOe(ioOe), .addrLenFour(addrLenFour), .wideInstr(wideInstr),
  .pinResetEn(pinResetEn), .readDummy(readDummy), .wideData(wideData), .progBusy(progBusy)
);

// file: testbench/serial_flash_boot_config_nv_tb_top.sv
// self-checking bench for the boot interface configuration block
// assumes the host model drives the link and the checker is bound in
`timescale 1ns/100ps
`include "boot_config_map.svh"
`define CHECK(what, exp, got) \
  begin \
    cmpCount++; \
    if ((got) !== (exp)) begin \
      nFail++; \
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module serial_flash_boot_config_nv_tb_top;
  logic       clk;
  logic       rstn;
  logic       swResetReq;
  logic       sck;
  logic       selN;
  logic [3:0] ioIn;
  logic [3:0] ioOut;
  logic [3:0] ioOe;
  logic       addrLenFour;
  logic       wideInstr;
  logic       pinResetEn;
  logic [3:0] readDummy;
  logic       wideData;
  logic       progBusy;
  logic       expFour;
  logic       expWide;
  logic [3:0] expDummy;
  logic [7:0] rdat;
  int         nFail;
  int         cmpCount;

  serial_flash_boot_config_nv serial_flash_boot_config_nv_inst (
    .clk(clk), .rstn(rstn), .swResetReq(swResetReq), .sck(sck), .selN(selN), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .addrLenFour(addrLenFour), .wideInstr(wideInstr),
    .pinResetEn(pinResetEn), .readDummy(readDummy), .wideData(wideData), .progBusy(progBusy)
  );
  spi_host_model spi_host_model_inst (
    .sck(sck), .selN(selN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic xfer(input logic [7:0] op, input logic [31:0] a, input logic [7:0] wd,
                      input bit rd);
    spi_host_model_inst.frame(op, a, expFour, expWide, expDummy, wd, rd, rdat);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(`BCFG_CMD_WRITE_ANY, a, d, 1'b0);
    repeat (6) @(posedge clk);
  endtask

  task automatic chkRd(input logic [31:0] a, input logic [7:0] exp);
    xfer(`BCFG_CMD_READ_ANY, a, 8'h00, 1'b1);
    `CHECK($sformatf("read %h", a), exp, rdat)
  endtask

  // order: address length, wide instr, pin reset, dummy count, wide data
  task automatic chkLive(input logic [7:0] exp);
    `CHECK("live outputs", exp, {addrLenFour, wideInstr, pinResetEn, readDummy, wideData})
  endtask

  task automatic waitIdle();
    for (int k = 0; k < 20; k++) begin
      xfer(`BCFG_CMD_READ_ANY, `BCFG_ADDR_STATUS_ONE, 8'h00, 1'b1);
      if (rdat[`BCFG_BIT_BUSY] === 1'b0)
        break;
    end
    `CHECK("busy bit", 1'b0, rdat[`BCFG_BIT_BUSY])
  endtask

  task automatic swReset();
    @(posedge clk);
    swResetReq <= 1'b1;
    repeat (4) @(posedge clk);
    swResetReq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic pinPulse();
    spi_host_model_inst.pinReset(200);
    repeat (4) @(posedge clk);
  endtask

  initial begin
    rstn = 1'b0;
    swResetReq = 1'b0;
    expFour = 1'b0;
    expWide = 1'b0;
    expDummy = 4'h8;
    nFail = 0;
    cmpCount = 0;
    spi_host_model_inst.resetClocks();
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chkLive(8'h10);
    chkRd(`BCFG_ADDR_BOOT_IFC, 8'h08);
    chkRd(`BCFG_ADDR_LIVE_IFC, 8'h08);
    chkRd(32'h0000_0040, 8'h00);
    xfer(8'h06, `BCFG_ADDR_LIVE_IFC, 8'hC0, 1'b0);
    chkRd(`BCFG_ADDR_LIVE_IFC, 8'h08);
    wr(`BCFG_ADDR_LIVE_IFC, 8'h93);
    expFour = 1'b1;
    expDummy = 4'h3;
    chkLive(8'h86);
    chkRd(`BCFG_ADDR_LIVE_IFC, 8'h83);
    pinPulse();
    chkLive(8'h86);
    wr(`BCFG_ADDR_LIVE_IFC, 8'h80);
    expDummy = 4'h0;
    chkRd(`BCFG_ADDR_LIVE_IFC, 8'h80);
    swReset();
    expFour = 1'b0;
    expDummy = 4'h8;
    chkLive(8'h10);
    wr(`BCFG_ADDR_BOOT_IFC, 8'hE7);
    `CHECK("prog busy", 1'b1, progBusy)
    waitIdle();
    chkLive(8'h10);
    chkRd(`BCFG_ADDR_BOOT_IFC, 8'hE7);
    chkRd(`BCFG_ADDR_BOOT_ONE, 8'h02);
    wr(`BCFG_ADDR_BOOT_IFC, 8'h08);
    waitIdle();
    chkRd(`BCFG_ADDR_BOOT_IFC, 8'hE7);
    swReset();
    expFour = 1'b1;
    expWide = 1'b1;
    expDummy = 4'h7;
    chkLive(8'hEF);
    chkRd(`BCFG_ADDR_LIVE_IFC, 8'hE7);
    wr(`BCFG_ADDR_LIVE_ONE, 8'h00);
    chkRd(`BCFG_ADDR_LIVE_ONE, 8'h02);
    wr(`BCFG_ADDR_LIVE_IFC, 8'h27);
    expFour = 1'b0;
    expWide = 1'b0;
    chkLive(8'h2F);
    chkRd(`BCFG_ADDR_LIVE_IFC, 8'h27);
    wr(`BCFG_ADDR_LIVE_IFC, 8'h67);
    expWide = 1'b1;
    chkRd(`BCFG_ADDR_LIVE_IFC, 8'h67);
    pinPulse();
    expFour = 1'b1;
    chkLive(8'hEF);
    chkRd(`BCFG_ADDR_LIVE_IFC, 8'hE7);
    complete_run();
  end

  // watchdog well beyond the expected run of some 90 us
  initial begin
    #800000;
    nFail++;
    complete_run();
  end
endmodule

// file: testbench/spi_host_model.sv
// behavioural host on the serial flash link: frames, dummy clocks, io3 pulse
// assumes mode 0 timing and pulled-up lines when nobody drives them
`timescale 1ns/100ps
module spi_host_model (
  output logic            sck,
  output logic            selN,
  output logic      [3:0] ioIn,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe
);
  localparam int HALF = 40;
  logic [3:0] hostVal;
  logic [3:0] hostOe;
  logic [3:0] seen;

  initial begin
    sck = 1'b0;
    selN = 1'b1;
    hostVal = 4'hF;
    hostOe = 4'h0;
  end

  // device drive wins, then host drive, else pull-up
  always_comb
    for (int i = 0; i < 4; i++)
      ioIn[i] = ioOe[i] ? ioOut[i] : (hostOe[i] ? hostVal[i] : 1'b1);

  // keep link edges away from system clock edges
  task automatic align();
    #(33 - $time % 10);
  endtask

  task automatic tick(input logic [3:0] v);
    hostVal = v;
    #HALF sck = 1'b1;
    seen = ioIn;
    #HALF sck = 1'b0;
  endtask

  task automatic shiftOut(input logic [31:0] v, input int nBits, input bit wide);
    for (int i = nBits - 1; i >= 0; i -= (wide ? 4 : 1))
      tick(wide ? v[i -: 4] : {3'b111, v[i]});
  endtask

  task automatic frame(input logic [7:0] op, input logic [31:0] a, input bit four,
                       input bit wide, input int dummy, input logic [7:0] wd,
                       input bit rd, output logic [7:0] rdat);
    rdat = 8'h00;
    align();
    selN = 1'b0;
    hostOe = wide ? 4'hF : 4'h1;
    #HALF;
    shiftOut({24'h0, op}, 8, wide);
    shiftOut(a, four ? 32 : 24, wide);
    if (rd) begin
      hostOe = 4'h0;
      repeat (dummy) tick(4'hF);
      for (int i = 7; i >= 0; i -= (wide ? 4 : 1)) begin
        tick(4'hF);
        if (wide)
          rdat[i -: 4] = seen;
        else
          rdat[i] = seen[1];
      end
    end else begin
      shiftOut({24'h0, wd}, 8, wide);
    end
    #HALF;
    selN = 1'b1;
    hostOe = 4'h0;
    #(2 * HALF);
  endtask

  task automatic resetClocks();
    repeat (2) tick(4'hF);
  endtask

  task automatic pinReset(input int ns);
    align();
    hostVal[3] = 1'b0;
    hostOe[3] = 1'b1;
    #(ns);
    hostOe[3] = 1'b0;
  endtask
endmodule
